// [flag_logic_consts.svh]
// flag register constants: bit positions, apb offsets, reset values
// assumes inclusion by bare name from the flag logic package and module
`ifndef FLAG_LOGIC_CONSTS_SVH
`define FLAG_LOGIC_CONSTS_SVH

`define FLG_BIT_SIGN 7
`define FLG_BIT_ZERO 6
`define FLG_BIT_HALF 4
`define FLG_BIT_PV 2
`define FLG_BIT_SUB 1
`define FLG_BIT_CARRY 0
`define FLG_USED_MASK 8'hd7

`define FLG_RESET 8'h00

`define OFF_FLAGS 12'h000
`define OFF_ALT_FLAGS 12'h004
`define OFF_OP_CTRL 12'h008
`define OFF_OPERANDS 12'h00c
`define OFF_AUX 12'h010
`define OFF_RESULT 12'h014
`define OFF_CONDS 12'h018

`define OPCODE_W 5

`endif

// [flag_logic_pkg.sv]
// types for the condition flag logic
// assumes flag_logic_consts.svh is on the include path
`include "flag_logic_consts.svh"

package flag_logic_pkg;

    typedef enum logic [`OPCODE_W-1:0] {
        op_none = 5'h00,
        op_add = 5'h01,
        op_adc = 5'h02,
        op_sub = 5'h03,
        op_sbc = 5'h04,
        op_cmp = 5'h05,
        op_and = 5'h06,
        op_or = 5'h07,
        op_xor = 5'h08,
        rotate_left_circular_acc = 5'h09,
        rotate_right_circular_acc = 5'h0a,
        rotate_left_through_carry = 5'h0b,
        rotate_right_through_carry = 5'h0c,
        arith_shift_left = 5'h0d,
        arith_shift_right = 5'h0e,
        logical_shift_right = 5'h0f,
        decimal_adjust_op = 5'h10,
        carry_set_op = 5'h11,
        carry_invert_op = 5'h12,
        op_bit_test = 5'h13,
        block_copy_incr_repeat = 5'h14,
        search_incr_repeat = 5'h15,
        block_input_incr = 5'h16,
        block_output_incr = 5'h17,
        op_port_in = 5'h18,
        op_load_special = 5'h19,
        op_exchange = 5'h1a
    } flag_op_t;

    // decoded flag word
    typedef struct packed {
        logic sign;
        logic zero;
        logic unused5;
        logic half;
        logic unused3;
        logic pv;
        logic sub;
        logic carry;
    } flag_word_t;

    // operands presented with a launch
    typedef struct packed {
        logic [7:0] acc;
        logic [7:0] opnd;
    } operand_pair_t;

    // side information from the datapath
    typedef struct packed {
        logic [15:0] byte_count;
        logic [7:0] b_count;
        logic [2:0] bit_sel;
        logic interrupt_enable_copy;
    } aux_info_t;

    typedef struct packed {
        logic cond_sign;
        logic cond_zero;
        logic cond_pv;
        logic cond_carry;
    } cond_out_t;

endpackage : flag_logic_pkg

// [condition_flag_logic.sv]
// condition flag generation and storage behind an apb slave
// assumes a single 25 mhz clock, synchronous high reset, apb3 master
//
// Chosen here: the address map and the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "flag_logic_consts.svh"

// Contract
// - flags in 8-bit register plus alternate: S7 Z6 PV2 N1 C0.
// - bits 3 and 5 never carry status information.
// - only carry, pv, zero, sign are exported as branch conditions.
// - carry set on add carry or subtract borrow, cleared otherwise.
// - decimal adjust sets carry when a correction is required.
// - through-carry rotates use carry as a ninth bit.
// - left shifts load carry from bit 7, right shifts from bit 0.
// - and, or, xor clear carry.
// - set-carry and complement-carry operations exist.
// - add/subtract flag is 0 for adds, 1 for subtracts.
// - add overflow when like-signed operands give differently signed result.
// - subtract overflow when unlike signs and result sign differs from minuend.
// - overflow computed as carry into sign xor carry out of sign.
// - logical and rotate ops load pv with even parity of result.
// - block search and copy clear pv when byte count reaches zero.
// - special accumulator loads copy interrupt enable copy into pv.
// - port input sets pv parity, zero and sign from input byte.
// - half carry from bit 3 on add, borrow from bit 4 on subtract.
// - arithmetic and logical ops set zero when result byte is zero.
// - compare and search set zero when accumulator equals memory byte.
// - bit test loads zero with inverse of the selected bit.
// - single block input/output sets zero when b minus one is zero.
// - sign equals bit 7 of the result.
module condition_flag_logic (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_reset,
    // apb slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // branch conditions and result
    output flag_logic_pkg::cond_out_t o_conds,
    output logic [7:0] o_flags,
    output logic [7:0] o_result
);

    ////////////////////////////////////////////////////////////////////////
    // register state

    logic [7:0] flags, alt_flags;
    flag_logic_pkg::operand_pair_t operands;
    flag_logic_pkg::aux_info_t aux;
    flag_logic_pkg::flag_op_t op_sel;
    logic launch;
    logic [7:0] result, next_flags, next_result;
    logic wr_en;
    logic addr_ok;

    function automatic logic even_parity(input logic [7:0] v);
        even_parity = ~^v;
    endfunction : even_parity
    // returns {carry_out, carry_into_bit7, half, result}
    function automatic logic [10:0] add8(input logic [7:0] a,
                                         input logic [7:0] b,
                                         input logic cin);
        logic [4:0] lo;
        logic [3:0] mid;
        logic [1:0] top;
        lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
        mid = {1'b0, a[6:4]} + {1'b0, b[6:4]} + {3'h0, lo[4]};
        top = {1'b0, a[7]} + {1'b0, b[7]} + {1'b0, mid[3]};
        add8 = {top[1], mid[3], lo[4], top[0], mid[2:0], lo[3:0]};
    endfunction : add8

    ////////////////////////////////////////////////////////////////////////
    // apb decode: zero wait states

    assign wr_en = i_psel && i_penable && i_pwrite && o_pready;
    assign addr_ok = (i_paddr[1:0] == 2'b00) && (i_paddr <= `OFF_CONDS);
    always_ff @(posedge i_sys_clk)
    begin
        if (i_reset)
        begin
            o_pready <= 1'b0;
            o_pslverr <= 1'b0;
        end
        else
        begin
            o_pready <= i_psel && !i_penable;
            o_pslverr <= i_psel && !i_penable && !addr_ok;
        end
    end

    always_ff @(posedge i_sys_clk)
    begin
        if (i_reset)
            o_prdata <= 32'h0000_0000;
        else if (i_psel && !i_penable && !i_pwrite)
        begin
            unique case (i_paddr)
                `OFF_FLAGS: o_prdata <= {24'h0, flags};
                `OFF_ALT_FLAGS: o_prdata <= {24'h0, alt_flags};
                `OFF_OP_CTRL: o_prdata <= {27'h0, op_sel};
                `OFF_OPERANDS: o_prdata <= {16'h0, operands};
                `OFF_AUX: o_prdata <= {4'h0, aux};
                `OFF_RESULT: o_prdata <= {24'h0, result};
                `OFF_CONDS: o_prdata <= {28'h0, o_conds};
                default: o_prdata <= 32'h0000_0000;
            endcase
        end
    end

    // configuration registers written by software
    always_ff @(posedge i_sys_clk)
    begin
        if (i_reset)
        begin
            operands <= '0;
            aux <= '0;
            op_sel <= flag_logic_pkg::op_none;
            launch <= 1'b0;
        end
        else
        begin
            launch <= 1'b0;
            if (wr_en)
            begin
                if (i_paddr == `OFF_OPERANDS)
                    operands <= i_pwdata[15:0];
                if (i_paddr == `OFF_AUX)
                    aux <= i_pwdata[27:0];
                if (i_paddr == `OFF_OP_CTRL)
                begin
                    op_sel <= flag_logic_pkg::flag_op_t'(i_pwdata[4:0]);
                    launch <= 1'b1;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // flag computation

    always_comb
    begin
        logic [10:0] s;
        logic [7:0] a;
        logic [7:0] b;
        logic [7:0] r;
        logic [7:0] corr;
        logic dc;
        logic sub;
        logic [15:0] cnt;
        s = '0;
        a = operands.acc;
        b = operands.opnd;
        r = 8'h00;
        corr = 8'h00;
        dc = 1'b0;
        sub = flags[`FLG_BIT_SUB];
        cnt = aux.byte_count - 16'h0001;
        next_flags = flags;
        next_result = result;
        unique case (op_sel)
            flag_logic_pkg::op_add, flag_logic_pkg::op_adc:
            begin
                s = add8(a, b, (op_sel == flag_logic_pkg::op_adc)
                    && flags[`FLG_BIT_CARRY]);
                next_result = s[7:0];
                next_flags[`FLG_BIT_CARRY] = s[10];
                next_flags[`FLG_BIT_HALF] = s[8];
                next_flags[`FLG_BIT_PV] = s[9] ^ s[10];
                next_flags[`FLG_BIT_SUB] = 1'b0;
            end
            flag_logic_pkg::op_sub, flag_logic_pkg::op_sbc,
            flag_logic_pkg::op_cmp:
            begin
                s = add8(a, ~b, !((op_sel == flag_logic_pkg::op_sbc)
                    && flags[`FLG_BIT_CARRY]));
                next_result = (op_sel == flag_logic_pkg::op_cmp)
                    ? result : s[7:0];
                next_flags[`FLG_BIT_CARRY] = !s[10];
                next_flags[`FLG_BIT_HALF] = !s[8];
                next_flags[`FLG_BIT_PV] = s[9] ^ s[10];
                next_flags[`FLG_BIT_SUB] = 1'b1;
            end
            flag_logic_pkg::op_and, flag_logic_pkg::op_or,
            flag_logic_pkg::op_xor:
            begin
                r = (op_sel == flag_logic_pkg::op_and) ? (a & b)
                    : (op_sel == flag_logic_pkg::op_or) ? (a | b) : (a ^ b);
                next_result = r;
                next_flags[`FLG_BIT_CARRY] = 1'b0;
                next_flags[`FLG_BIT_HALF] = (op_sel == flag_logic_pkg::op_and);
                next_flags[`FLG_BIT_PV] = even_parity(r);
                next_flags[`FLG_BIT_SUB] = 1'b0;
            end
            flag_logic_pkg::rotate_left_circular_acc,
            flag_logic_pkg::rotate_right_circular_acc,
            flag_logic_pkg::rotate_left_through_carry,
            flag_logic_pkg::rotate_right_through_carry,
            flag_logic_pkg::arith_shift_left,
            flag_logic_pkg::arith_shift_right,
            flag_logic_pkg::logical_shift_right:
            begin
                unique case (op_sel)
                    flag_logic_pkg::rotate_left_circular_acc:
                        r = {b[6:0], b[7]};
                    flag_logic_pkg::rotate_right_circular_acc:
                        r = {b[0], b[7:1]};
                    flag_logic_pkg::rotate_left_through_carry:
                        r = {b[6:0], flags[`FLG_BIT_CARRY]};
                    flag_logic_pkg::rotate_right_through_carry:
                        r = {flags[`FLG_BIT_CARRY], b[7:1]};
                    flag_logic_pkg::arith_shift_left:
                        r = {b[6:0], 1'b0};
                    flag_logic_pkg::arith_shift_right:
                        r = {b[7], b[7:1]};
                    default:
                        r = {1'b0, b[7:1]};
                endcase
                next_result = r;
                next_flags[`FLG_BIT_CARRY] =
                    (op_sel == flag_logic_pkg::rotate_left_circular_acc
                     || op_sel == flag_logic_pkg::rotate_left_through_carry
                     || op_sel == flag_logic_pkg::arith_shift_left)
                    ? b[7] : b[0];
                next_flags[`FLG_BIT_HALF] = 1'b0;
                next_flags[`FLG_BIT_PV] = even_parity(r);
                next_flags[`FLG_BIT_SUB] = 1'b0;
            end
            flag_logic_pkg::decimal_adjust_op:
            begin
                dc = flags[`FLG_BIT_CARRY] || (a > 8'h99);
                corr = {1'b0, dc, dc, 2'b00,
                    flags[`FLG_BIT_HALF] || (a[3:0] > 4'h9),
                    flags[`FLG_BIT_HALF] || (a[3:0] > 4'h9), 1'b0};
                r = sub ? (a - corr) : (a + corr);
                next_result = r;
                next_flags[`FLG_BIT_CARRY] = dc;
                next_flags[`FLG_BIT_HALF] = sub
                    ? (flags[`FLG_BIT_HALF] && (a[3:0] < 4'h6))
                    : (a[3:0] > 4'h9);
                next_flags[`FLG_BIT_PV] = even_parity(r);
            end
            flag_logic_pkg::carry_set_op:
            begin
                next_flags[`FLG_BIT_CARRY] = 1'b1;
                next_flags[`FLG_BIT_HALF] = 1'b0;
                next_flags[`FLG_BIT_SUB] = 1'b0;
            end
            flag_logic_pkg::carry_invert_op:
            begin
                next_flags[`FLG_BIT_CARRY] = !flags[`FLG_BIT_CARRY];
                next_flags[`FLG_BIT_HALF] = flags[`FLG_BIT_CARRY];
                next_flags[`FLG_BIT_SUB] = 1'b0;
            end
            flag_logic_pkg::op_bit_test:
            begin
                next_flags[`FLG_BIT_ZERO] = !b[aux.bit_sel];
                next_flags[`FLG_BIT_HALF] = 1'b1;
                next_flags[`FLG_BIT_SUB] = 1'b0;
            end
            flag_logic_pkg::block_copy_incr_repeat,
            flag_logic_pkg::search_incr_repeat:
            begin
                next_flags[`FLG_BIT_PV] = (cnt != 16'h0000);
                next_flags[`FLG_BIT_HALF] = 1'b0;
                next_flags[`FLG_BIT_SUB] = 1'b0;
                if (op_sel == flag_logic_pkg::search_incr_repeat)
                begin
                    s = add8(a, ~b, 1'b1);
                    next_flags[`FLG_BIT_ZERO] = (a == b);
                    next_flags[`FLG_BIT_SIGN] = s[7];
                    next_flags[`FLG_BIT_HALF] = !s[8];
                    next_flags[`FLG_BIT_SUB] = 1'b1;
                end
            end
            flag_logic_pkg::block_input_incr,
            flag_logic_pkg::block_output_incr:
            begin
                next_flags[`FLG_BIT_ZERO] = (aux.b_count == 8'h01);
                next_flags[`FLG_BIT_SUB] = 1'b1;
            end
            flag_logic_pkg::op_port_in:
            begin
                next_result = b;
                next_flags[`FLG_BIT_PV] = even_parity(b);
                next_flags[`FLG_BIT_ZERO] = (b == 8'h00);
                next_flags[`FLG_BIT_SIGN] = b[7];
                next_flags[`FLG_BIT_HALF] = 1'b0;
                next_flags[`FLG_BIT_SUB] = 1'b0;
            end
            flag_logic_pkg::op_load_special:
            begin
                next_result = b;
                next_flags[`FLG_BIT_PV] = aux.interrupt_enable_copy;
                next_flags[`FLG_BIT_ZERO] = (b == 8'h00);
                next_flags[`FLG_BIT_SIGN] = b[7];
                next_flags[`FLG_BIT_HALF] = 1'b0;
                next_flags[`FLG_BIT_SUB] = 1'b0;
            end
            default: ;
        endcase
        if (op_sel inside {[flag_logic_pkg::op_add :
            flag_logic_pkg::decimal_adjust_op]})
        begin
            r = (op_sel == flag_logic_pkg::op_cmp) ? s[7:0] : next_result;
            next_flags[`FLG_BIT_ZERO] = (r == 8'h00);
            next_flags[`FLG_BIT_SIGN] = r[7];
        end
        next_flags = next_flags & `FLG_USED_MASK;
    end

    ////////////////////////////////////////////////////////////////////////
    // flag register, alternate copy and outputs

    always_ff @(posedge i_sys_clk)
    begin
        if (i_reset)
        begin
            flags <= `FLG_RESET;
            alt_flags <= `FLG_RESET;
            result <= 8'h00;
        end
        else if (wr_en && i_paddr == `OFF_FLAGS)
            flags <= i_pwdata[7:0] & `FLG_USED_MASK;
        else if (wr_en && i_paddr == `OFF_ALT_FLAGS)
            alt_flags <= i_pwdata[7:0] & `FLG_USED_MASK;
        else if (launch && op_sel == flag_logic_pkg::op_exchange)
        begin
            flags <= alt_flags;
            alt_flags <= flags;
        end
        else if (launch)
        begin
            flags <= next_flags;
            result <= next_result;
        end
    end

    always_ff @(posedge i_sys_clk)
    begin
        if (i_reset)
        begin
            o_conds <= '0;
            o_flags <= `FLG_RESET;
            o_result <= 8'h00;
        end
        else
        begin
            o_conds <= {flags[`FLG_BIT_SIGN], flags[`FLG_BIT_ZERO],
                flags[`FLG_BIT_PV], flags[`FLG_BIT_CARRY]};
            o_flags <= flags;
            o_result <= result;
        end
    end

endmodule : condition_flag_logic
`default_nettype wire

// [condition_flag_logic_chk.sv]
// checker for the condition flag logic apb ports and flag outputs
// assumes a bind onto condition_flag_logic, one clock domain
`timescale 1ns/1ns
`default_nettype none
module condition_flag_logic_chk (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_reset,
    // apb slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [31:0] o_prdata,
    input wire logic o_pready,
    input wire logic o_pslverr,
    // conditions and flags
    input wire flag_logic_pkg::cond_out_t o_conds,
    input wire logic [7:0] o_flags,
    input wire logic [7:0] o_result
);
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (i_reset);

    ////////////////////////////////////////////////////////////////////////
    wire logic aligned = i_paddr[1:0] == 2'b00;
    wire logic hit = aligned && i_paddr <= 12'h018;
    wire logic miss = aligned && i_paddr > 12'h018;

    sequence setup_s;
        i_psel && !i_penable;
    endsequence
    sequence done_wr_s(logic [11:0] a);
        i_psel && i_penable && o_pready && i_pwrite && i_paddr == a;
    endsequence

    ////////////////////////////////////////////////////////////////////////
    pready_after_setup_a: assert property (setup_s |=> o_pready)
        else $error("no ready after setup");
    pready_in_access_a: assert property (o_pready |-> i_psel && i_penable)
        else $error("ready outside access");
    pready_one_cycle_a: assert property (o_pready |=> !o_pready)
        else $error("ready longer than one cycle");
    slverr_unmapped_a: assert property ((setup_s and miss) |=> o_pslverr)
        else $error("no error on unmapped address");
    slverr_mapped_a: assert property ((setup_s and hit) |=> !o_pslverr)
        else $error("error on mapped address");
    err_read_zero_a: assert property
        (o_pready && o_pslverr && !i_pwrite |-> o_prdata == 32'h0)
        else $error("unmapped read not zero");
    flag_write_a: assert property (done_wr_s(12'h000) |->
        ##2 o_flags == ($past(i_pwdata[7:0], 2) & 8'hd7))
        else $error("flag write not applied");
    unused_bits_a: assert property (o_flags[5] == 1'b0 && !o_flags[3])
        else $error("unused flag bit set");
    cond_map_a: assert property (o_conds ==
        {o_flags[7], o_flags[6], o_flags[2], o_flags[0]})
        else $error("branch conditions differ from flags");
    carry_set_a: assert property ((done_wr_s(12'h008) and i_pwdata[4:0] ==
        5'h11) |-> ##3 o_flags[0])
        else $error("carry not set");
    carry_invert_a: assert property ((done_wr_s(12'h008) and i_pwdata[4:0] ==
        5'h12) |-> ##3 o_flags[0] != $past(o_flags[0], 3))
        else $error("carry not inverted");
endmodule : condition_flag_logic_chk
`default_nettype wire

// [tb_top.sv]
// self-checking bench for the condition flag logic over apb
// assumes the package, the constants header and the checker are compiled
`timescale 1ns/1ns
`default_nettype none
`include "flag_logic_consts.svh"
module tb_top;
    logic sys_clk, reset, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [7:0] flags, result;
    flag_logic_pkg::cond_out_t conds;
    flag_logic_pkg::aux_info_t x0, x1, xa;
    logic [31:0] rng = 32'h0000_003f;
    logic [31:0] r1, r2;
    logic [4:0] op;
    logic [7:0] fl;
    logic er;
    int miscompares = 0;
    int tests_run = 0;

    condition_flag_logic condition_flag_logic_i (.i_sys_clk(sys_clk),
        .i_reset(reset), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
        .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
        .o_conds(conds), .o_flags(flags), .o_result(result));

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction : rnd

    // returns {result valid, checked mask, result, flags}
    function automatic logic [24:0] model(input logic [4:0] o,
        input logic [7:0] a, input logic [7:0] b,
        input flag_logic_pkg::aux_info_t x, input logic [7:0] f);
        flag_logic_pkg::flag_word_t w;
        logic [7:0] m, r;
        logic [8:0] s;
        logic [4:0] h;
        logic ci, rv;
        w = 8'h00;
        m = 8'h05;
        r = b;
        rv = 1'b1;
        ci = (o == 5'h02 || o == 5'h04) ? f[0] : 1'b0;
        case (o)
            5'h01, 5'h02:
            begin
                s = {1'b0, a} + {1'b0, b} + {8'h00, ci};
                h = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
                w.pv = a[7] == b[7] && s[7] != a[7];
            end
            5'h03, 5'h04, 5'h05:
            begin
                s = {1'b0, a} - {1'b0, b} - {8'h00, ci};
                h = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, ci};
                w.pv = a[7] != b[7] && s[7] != a[7];
                w.sub = 1'b1;
                rv = o != 5'h05;
            end
            5'h06: r = a & b;
            5'h07: r = a | b;
            5'h08: r = a ^ b;
            5'h09: {w.carry, r} = {b[7], b[6:0], b[7]};
            5'h0a: {r, w.carry} = {b[0], b[7:1], b[0]};
            5'h0b: {w.carry, r} = {b, f[0]};
            5'h0c: {r, w.carry} = {f[0], b};
            5'h0d: {w.carry, r} = {b, 1'b0};
            5'h0e: {r, w.carry} = {b[7], b};
            5'h0f: {r, w.carry} = {1'b0, b};
            default: rv = 1'b0;
        endcase
        if (o <= 5'h05)
        begin
            {w.carry, r} = s;
            w.half = h[4];
            m = 8'hd7;
        end
        if (o >= 5'h06 && o <= 5'h0f)
            w.pv = ~^r;
        if (o >= 5'h06 && o <= 5'h08)
            m = 8'hc5;
        if (o <= 5'h08)
            {w.sign, w.zero} = {r[7], r == 8'h00};
        case (o)
            5'h10: {m, w.carry} = {8'h01, f[0] | (a > 8'h99)};
            5'h11: {m, w.carry} = {8'h01, 1'b1};
            5'h12: {m, w.carry} = {8'h01, ~f[0]};
            5'h13: {m, w.zero} = {8'h40, ~b[x.bit_sel]};
            5'h14: {m, w.pv} = {8'h04, x.byte_count != 16'h0001};
            5'h15: {m, w.pv, w.zero} = {8'h44, x.byte_count != 16'h0001, a == b};
            5'h16, 5'h17: {m, w.zero} = {8'h40, x.b_count == 8'h01};
            5'h18: {m, w.sign, w.zero, w.pv} = {8'hc4, b[7], b == 8'h00, ~^b};
            5'h19: {m, w.pv} = {8'h04, x.interrupt_enable_copy};
            5'h1a: m = 8'h00;
            default: ;
        endcase
        return {rv, m, r, w};
    endfunction : model

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
        input logic [31:0] m);
        tests_run++;
        if ((got & m) !== (exp & m))
        begin
            miscompares++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic apb(input logic [11:0] a, input logic w,
        input logic [31:0] d, output logic [31:0] q, output logic e);
        int n;
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge sys_clk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (n >= 20)
            chk(32'h1, 32'h0, 32'h1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic do_op(input logic [4:0] o, input logic [7:0] a,
        input logic [7:0] b, input flag_logic_pkg::aux_info_t x,
        input logic [7:0] f);
        logic [24:0] e;
        logic [31:0] q;
        logic g;
        e = model(o, a, b, x, f);
        apb(`OFF_FLAGS, 1'b1, {24'h0, f}, q, g);
        apb(`OFF_OPERANDS, 1'b1, {16'h0, a, b}, q, g);
        apb(`OFF_AUX, 1'b1, {4'h0, x}, q, g);
        apb(`OFF_OP_CTRL, 1'b1, {27'h0, o}, q, g);
        repeat (3) @(posedge sys_clk);
        apb(`OFF_FLAGS, 1'b0, 32'h0, q, g);
        chk(q, {24'h0, e[7:0]}, {24'h0, e[23:16] | 8'h28});
        if (e[24])
            chk({24'h0, result}, {24'h0, e[15:8]}, 32'hff);
    endtask : do_op

    task report_and_stop();
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : report_and_stop

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    initial
    begin
        #(40 * 20000);
        miscompares++;
        report_and_stop();
    end

    initial
    begin
        {reset, psel, penable, pwrite, paddr, pwdata} = {1'b1, 47'h0};
        x0 = '0;
        x1 = '{16'h0001, 8'h01, 3'd3, 1'b1};
        repeat (16) @(posedge sys_clk);
        reset <= 1'b0;
        apb(`OFF_FLAGS, 1'b0, 32'h0, rd, er);
        chk(rd, 32'h0, 32'hffffffff);
        apb(`OFF_ALT_FLAGS, 1'b0, 32'h0, rd, er);
        chk(rd, 32'h0, 32'hffffffff);
        apb(12'h01c, 1'b0, 32'h0, rd, er);
        chk({rd[30:0], er}, 32'h1, 32'hffffffff);
        apb(`OFF_ALT_FLAGS, 1'b1, 32'h13, rd, er);
        do_op(5'h1a, 8'h00, 8'h00, x0, 8'hc5);
        apb(`OFF_ALT_FLAGS, 1'b0, 32'h0, rd, er);
        chk(rd, 32'hc5, 32'hffffffff);
        chk({24'h0, flags}, 32'h13, 32'hff);
        apb(`OFF_RESULT, 1'b1, 32'h5a, rd, er);
        apb(`OFF_RESULT, 1'b0, 32'h0, rd, er);
        chk(rd, 32'h0, 32'hffffffff);
        do_op(5'h01, 8'h78, 8'h69, x0, 8'h00);
        do_op(5'h03, 8'h7f, 8'hc0, x0, 8'h00);
        do_op(5'h01, 8'hff, 8'h01, x0, 8'h00);
        do_op(5'h04, 8'h10, 8'h00, x0, 8'h01);
        do_op(5'h10, 8'h9a, 8'h00, x0, 8'h00);
        do_op(5'h11, 8'h00, 8'h00, x0, 8'h00);
        do_op(5'h12, 8'h00, 8'h00, x0, 8'h01);
        do_op(5'h0b, 8'h00, 8'h80, x0, 8'h01);
        do_op(5'h0c, 8'h00, 8'h01, x0, 8'h01);
        do_op(5'h06, 8'h0f, 8'hf0, x0, 8'hff);
        do_op(5'h13, 8'h00, 8'h08, x1, 8'h00);
        do_op(5'h14, 8'h00, 8'h00, x1, 8'h04);
        do_op(5'h15, 8'h3c, 8'h3c, x0, 8'h00);
        do_op(5'h05, 8'h81, 8'h81, x0, 8'h00);
        do_op(5'h16, 8'h00, 8'h00, x1, 8'h00);
        do_op(5'h17, 8'h00, 8'h00, x0, 8'h40);
        do_op(5'h18, 8'h00, 8'h00, x0, 8'h00);
        do_op(5'h19, 8'h00, 8'h00, x1, 8'h00);
        for (int i = 0; i < 150; i++)
        begin
            r1 = rnd();
            r2 = rnd();
            op = 5'd1 + 5'(r1[7:0] % 25);
            xa = r2[27:0];
            if (r1[8])
                {xa.byte_count, xa.b_count} = {16'h0001, 8'h01};
            fl = r1[31:24];
            if (op == 5'h10)
                fl[1] = 1'b0;
            do_op(op, r1[23:16], r1[15:8], xa, fl);
        end
        report_and_stop();
    end
endmodule : tb_top

bind condition_flag_logic condition_flag_logic_chk condition_flag_logic_chk_i (
    .i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_psel(i_psel),
    .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
    .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
    .o_pslverr(o_pslverr), .o_conds(o_conds), .o_flags(o_flags),
    .o_result(o_result));
`default_nettype wire
